// [rtl/tcc_timer16.sv]
// wide timer control, reload hold and capture registers behind an axi4-lite slave
// Functional notes
// - narrow high capture holds count while input one
// - narrow low capture holds count while input zero
// - wide high capture holds captured upper byte
// - wide low capture holds captured lower byte
// - writes to capture registers change nothing
// - reload high byte readable and writable
// - run bit starts, stops, reads state
// - bit six: single/modulo or edge ignore
// - timeout flag set by hardware, write-one clears
// - bits four-three select clock divide one-eight
// - bit two gates capture interrupt request
// - bit one gates timeout interrupt request
// - bit zero routes timer output to pin
// - some fields survive stop-mode recovery
// - modulo reloads, single pass stops at terminal
// - demodulation wraps zero to ffff, flags timeout
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
module tcc_timer16 (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic [7:0]         s_axi_awaddr,
	input  wire logic [2:0]         s_axi_awprot,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [7:0]         s_axi_araddr,
	input  wire logic [2:0]         s_axi_arprot,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	input  wire tcc_pkg::tcc_narrow_s narrow_in,
	input  wire logic               demod_in,
	input  wire logic               stop_recover,
	input  wire logic               port_out_data,
	output logic                    timer_output_pin,
	output logic                    wide_out,
	output logic                    capture_irq_req,
	output logic                    timeout_irq_req
);
	tcc_pkg::tcc_state_s s;          // registered state
	tcc_pkg::tcc_state_s next_s;     // next value of the state
	logic                tick;       // one-cycle count enable
	logic [2:0]          sel_mask;   // prescaler compare mask
	logic                edge_seen;  // filtered input change
	logic                stable;     // second and third sync stages agree
	logic                terminal;   // counter at terminal count on a tick
	logic                cap_take;   // wide capture this cycle
	logic                to_set;     // timeout event this cycle
	logic                to_clr;     // software clears timeout
	logic                wr_fire;    // register write performed this cycle
	logic                wr_ctrl;    // write hits the control register
	logic                rd_fire;    // read address taken this cycle
	logic [7:0]          rd_byte;    // decoded read data
	logic                rd_hit;     // read address is mapped
	logic                wr_hit;     // write address is mapped

	// handshake outputs are combinational from state
	assign s_axi_awready    = !s.aw_got && !s.bvalid;
	assign s_axi_wready     = !s.w_got && !s.bvalid;
	assign s_axi_arready    = !s.rvalid;
	assign s_axi_bvalid     = s.bvalid;
	assign s_axi_bresp      = s.bresp;
	assign s_axi_rvalid     = s.rvalid;
	assign s_axi_rresp      = s.rresp;
	assign s_axi_rdata      = {24'h000000, s.rdata};
	assign timer_output_pin = s.pin;
	assign wide_out         = s.wide_out;
	assign capture_irq_req  = s.cap_irq;
	assign timeout_irq_req  = s.to_irq;

	// next-state logic: sync, prescaler, counter, captures, bus slave
	always_comb begin
		next_s   = s;
		tick     = 1'b0;
		sel_mask = 3'h0;
		edge_seen = 1'b0;
		stable   = 1'b0;
		terminal = 1'b0;
		cap_take = 1'b0;
		to_set   = 1'b0;
		to_clr   = 1'b0;
		wr_fire  = 1'b0;
		wr_ctrl  = 1'b0;
		rd_fire  = 1'b0;
		rd_byte  = tcc_pkg::RST_BYTE;
		rd_hit   = 1'b1;
		wr_hit   = 1'b1;
		next_s.cap_irq = 1'b0;
		next_s.to_irq  = 1'b0;

		// input synchroniser; stage 0 feeds stage 1 only
		// an edge is believed only when the last two stages agree, so a
		// metastable first stage never produces an edge on its own
		next_s.sync = {s.sync[1:0], demod_in};
		stable      = (s.sync[1] == s.sync[2]);
		edge_seen   = stable && (s.sync[2] != s.level);
		if (edge_seen) begin
			next_s.level = s.sync[2];
		end

		// prescaler free runs; tick when the low bits all reach one
		// a start clears it so the first tick always comes a full period later
		unique case (s.ctrl.presc_sel)
			2'h0: sel_mask = 3'h0;
			2'h1: sel_mask = 3'h1;
			2'h2: sel_mask = 3'h3;
			2'h3: sel_mask = 3'h7;
		endcase
		next_s.presc = s.presc + 3'h1;
		tick = ((s.presc & sel_mask) == sel_mask);

		// counting engine
		if (s.ctrl.run) begin
			if (s.demod) begin
				// bit six set ignores edges once armed; the first edge still starts
				// the measurement, otherwise the counter could never run or time out
				if (edge_seen && !(s.ctrl.single && s.armed)) begin
					if (s.armed) begin
						cap_take     = 1'b1;
						next_s.cap16 = ~s.count;
						next_s.count = tcc_pkg::COUNT_FULL;
					end else begin
						// first edge only arms and starts from full
						next_s.armed = 1'b1;
						next_s.count = tcc_pkg::COUNT_FULL;
					end
				end else if (tick && s.armed) begin
					if (s.count == tcc_pkg::COUNT_ZERO) begin
						// wrap keeps measuring; software sees the flag
						next_s.count = tcc_pkg::COUNT_FULL;
						to_set       = 1'b1;
					end else begin
						next_s.count = s.count - 16'h0001;
					end
				end
			end else if (tick) begin
				if (s.count == tcc_pkg::COUNT_ZERO) begin
					terminal        = 1'b1;
					to_set          = 1'b1;
					next_s.wide_out = !s.wide_out;
					if (s.ctrl.single) begin
						next_s.ctrl.run = 1'b0;
					end else begin
						next_s.count = {s.reload_hi, s.reload_lo};
					end
				end else begin
					next_s.count = s.count - 16'h0001;
				end
			end
		end

		// narrow engine captures pass straight into their registers
		if (narrow_in.cap_high) begin
			next_s.cap8_hi = narrow_in.count;
		end
		if (narrow_in.cap_low) begin
			next_s.cap8_lo = narrow_in.count;
		end

		// interrupt requests are single-cycle and gated by their masks
		next_s.cap_irq = cap_take && s.ctrl.cap_mask;
		next_s.to_irq  = to_set && s.ctrl.to_mask;

		// write channels are taken independently, in either order
		// each half is held until its partner arrives; the response waits for both
		if (s_axi_awvalid && s_axi_awready) begin
			next_s.aw_got = 1'b1;
			next_s.waddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_s.w_got  = 1'b1;
			next_s.wdata  = s_axi_wdata[7:0];
			next_s.wstrb0 = s_axi_wstrb[0];
		end

		// write is performed once both halves are held
		wr_fire = s.aw_got && s.w_got && !s.bvalid;
		if (wr_fire) begin
			next_s.aw_got = 1'b0;
			next_s.w_got  = 1'b0;
			next_s.bvalid = 1'b1;
			wr_ctrl       = (s.waddr == tcc_pkg::ADDR_CONTROL) && s.wstrb0;
			unique case (s.waddr)
				tcc_pkg::ADDR_CONTROL: begin
					if (s.wstrb0) begin
						// starting loads the reload value and restarts the divider
						if (s.wdata[tcc_pkg::BIT_RUN] && !s.ctrl.run) begin
							next_s.count = {s.reload_hi, s.reload_lo};
							next_s.presc = tcc_pkg::PRESC_RST;
							next_s.armed = 1'b0;
						end
						next_s.ctrl.run       = s.wdata[tcc_pkg::BIT_RUN];
						next_s.ctrl.single    = s.wdata[tcc_pkg::BIT_SINGLE];
						to_clr                = s.wdata[tcc_pkg::BIT_TIMEOUT];
						next_s.ctrl.presc_sel = s.wdata[tcc_pkg::BIT_CLK_HI:tcc_pkg::BIT_CLK_LO];
						next_s.ctrl.cap_mask  = s.wdata[tcc_pkg::BIT_CAP_MASK];
						next_s.ctrl.to_mask   = s.wdata[tcc_pkg::BIT_TO_MASK];
						next_s.ctrl.route     = s.wdata[tcc_pkg::BIT_ROUTE];
					end
				end
				tcc_pkg::ADDR_RELOAD_HI: begin
					if (s.wstrb0) begin
						next_s.reload_hi = s.wdata;
					end
				end
				tcc_pkg::ADDR_RELOAD_LO: begin
					if (s.wstrb0) begin
						next_s.reload_lo = s.wdata;
					end
				end
				tcc_pkg::ADDR_MODE: begin
					if (s.wstrb0) begin
						next_s.demod = s.wdata[tcc_pkg::BIT_DEMOD];
						next_s.armed = 1'b0;
					end
				end
				// captured data cannot be overwritten by software
				tcc_pkg::ADDR_CAP16_LO, tcc_pkg::ADDR_CAP16_HI,
				tcc_pkg::ADDR_CAP8_LO, tcc_pkg::ADDR_CAP8_HI: begin
					wr_hit = 1'b1;
				end
				default: begin
					wr_hit = 1'b0;
				end
			endcase
			next_s.bresp = wr_hit ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end

		// hardware set wins over a software clear in the same cycle
		next_s.ctrl.timeout = (s.ctrl.timeout && !to_clr) || to_set;

		// read decode answers one cycle after the address is taken
		// the decode runs every cycle, only the address handshake latches it
		unique case (s_axi_araddr)
			tcc_pkg::ADDR_CONTROL:   rd_byte = s.ctrl;
			tcc_pkg::ADDR_RELOAD_HI: rd_byte = s.reload_hi;
			tcc_pkg::ADDR_RELOAD_LO: rd_byte = s.reload_lo;
			tcc_pkg::ADDR_CAP16_LO:  rd_byte = s.cap16[7:0];
			tcc_pkg::ADDR_CAP16_HI:  rd_byte = s.cap16[15:8];
			tcc_pkg::ADDR_CAP8_LO:   rd_byte = s.cap8_lo;
			tcc_pkg::ADDR_CAP8_HI:   rd_byte = s.cap8_hi;
			tcc_pkg::ADDR_MODE:      rd_byte = {7'h00, s.demod};
			default: begin
				rd_byte = tcc_pkg::RST_BYTE;
				rd_hit  = 1'b0;
			end
		endcase
		rd_fire = s_axi_arvalid && s_axi_arready;
		if (rd_fire) begin
			next_s.rvalid = 1'b1;
			next_s.rdata  = rd_byte;
			next_s.rresp  = rd_hit ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
		end else if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end

		// stop-mode recovery clears only the power-on fields
		// divide select, capture mask and the flag are left alone on purpose
		if (stop_recover) begin
			next_s.ctrl.run     = 1'b0;
			next_s.ctrl.to_mask = 1'b0;
			next_s.ctrl.route   = 1'b0;
		end

		// pin mux is registered so the pin never glitches on a route change
		next_s.pin = s.ctrl.route ? s.wide_out : port_out_data;
	end

	// state register with synchronous reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s       <= '0;
			s.count <= tcc_pkg::COUNT_FULL;
		end else begin
			s <= next_s;
		end
	end

	// rule checks; grouped together after the state register, each carries its tag
	a_narrow_high: assert property (@(posedge aclk) disable iff (!aresetn)
		narrow_in.cap_high |=> s.cap8_hi == $past(narrow_in.count))
		else $error("narrow high capture lost");
	a_narrow_low: assert property (@(posedge aclk) disable iff (!aresetn)
		narrow_in.cap_low |=> s.cap8_lo == $past(narrow_in.count))
		else $error("narrow low capture lost");
	a_wide_capture: assert property (@(posedge aclk) disable iff (!aresetn)
		cap_take |=> s.cap16 == ~$past(s.count) && s.count == tcc_pkg::COUNT_FULL)
		else $error("wide capture value wrong");
	a_cap_write_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && s.waddr == tcc_pkg::ADDR_CAP16_HI && !cap_take |=> $stable(s.cap16))
		else $error("capture changed by write");
	a_run_start: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_ctrl && s.wdata[tcc_pkg::BIT_RUN] && !s.ctrl.run && !stop_recover
		|=> s.ctrl.run && s.count == {s.reload_hi, s.reload_lo})
		else $error("start did not load counter");
	a_timeout_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_ctrl && s.wdata[tcc_pkg::BIT_TIMEOUT] |=> s.ctrl.timeout == $past(to_set))
		else $error("timeout flag clear wrong");
	a_presc_ratio: assert property (@(posedge aclk) disable iff (!aresetn)
		(tick && s.ctrl.presc_sel == 2'h1) ##1 (s.ctrl.presc_sel == 2'h1 && !wr_fire)
		|-> !tick ##1 tick)
		else $error("divide by two ratio wrong");
	a_mod_reload: assert property (@(posedge aclk) disable iff (!aresetn)
		terminal && !s.ctrl.single && !wr_fire
		|=> s.count == {s.reload_hi, s.reload_lo} && s.ctrl.timeout)
		else $error("modulo reload missing");
	a_single_stop: assert property (@(posedge aclk) disable iff (!aresetn)
		terminal && s.ctrl.single && !wr_ctrl |=> !s.ctrl.run)
		else $error("single pass did not stop");
	a_demod_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
		s.demod && s.ctrl.run && s.armed && tick && s.count == tcc_pkg::COUNT_ZERO
		&& !edge_seen && !wr_fire |=> s.count == tcc_pkg::COUNT_FULL && s.ctrl.timeout)
		else $error("demodulation wrap wrong");
	a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		s.cap_irq |-> $past(s.ctrl.cap_mask) && $past(cap_take))
		else $error("capture request without mask");
	a_to_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(to_set) && $past(s.ctrl.to_mask) |-> s.to_irq)
		else $error("timeout request missing");
	a_pin_route: assert property (@(posedge aclk) disable iff (!aresetn)
		s.ctrl.route |=> s.pin == $past(s.wide_out))
		else $error("pin not routed to timer");
	a_recover_keep: assert property (@(posedge aclk) disable iff (!aresetn)
		stop_recover && !wr_fire |=> !s.ctrl.run && $stable(s.ctrl.presc_sel)
		&& $stable(s.ctrl.cap_mask))
		else $error("recovery touched kept fields");
endmodule : tcc_timer16

// [include/tcc_pkg.sv]
// package for the wide timer control and capture block: map, fields, state
package tcc_pkg;
	// register indices as printed, byte address is four times the index
	localparam logic [7:0] IDX_CONTROL    = 8'h02;
	localparam logic [7:0] IDX_RELOAD_LO  = 8'h06;
	localparam logic [7:0] IDX_RELOAD_HI  = 8'h07;
	localparam logic [7:0] IDX_CAP16_LO   = 8'h08;
	localparam logic [7:0] IDX_CAP16_HI   = 8'h09;
	localparam logic [7:0] IDX_CAP8_LO    = 8'h0a;
	localparam logic [7:0] IDX_CAP8_HI    = 8'h0b;
	localparam logic [7:0] IDX_MODE       = 8'h0c;
	localparam logic [7:0] ADDR_CONTROL   = {IDX_CONTROL[5:0], 2'h0};
	localparam logic [7:0] ADDR_RELOAD_LO = {IDX_RELOAD_LO[5:0], 2'h0};
	localparam logic [7:0] ADDR_RELOAD_HI = {IDX_RELOAD_HI[5:0], 2'h0};
	localparam logic [7:0] ADDR_CAP16_LO  = {IDX_CAP16_LO[5:0], 2'h0};
	localparam logic [7:0] ADDR_CAP16_HI  = {IDX_CAP16_HI[5:0], 2'h0};
	localparam logic [7:0] ADDR_CAP8_LO   = {IDX_CAP8_LO[5:0], 2'h0};
	localparam logic [7:0] ADDR_CAP8_HI   = {IDX_CAP8_HI[5:0], 2'h0};
	localparam logic [7:0] ADDR_MODE      = {IDX_MODE[5:0], 2'h0};
	// control register field positions
	localparam int BIT_RUN      = 7;
	localparam int BIT_SINGLE   = 6;
	localparam int BIT_TIMEOUT  = 5;
	localparam int BIT_CLK_HI   = 4;
	localparam int BIT_CLK_LO   = 3;
	localparam int BIT_CAP_MASK = 2;
	localparam int BIT_TO_MASK  = 1;
	localparam int BIT_ROUTE    = 0;
	localparam int BIT_DEMOD    = 0;
	// values after reset and fixed counts
	localparam logic [7:0]  RST_BYTE    = 8'h00;
	localparam logic [15:0] COUNT_FULL  = 16'hffff;
	localparam logic [15:0] COUNT_ZERO  = 16'h0000;
	localparam logic [2:0]  PRESC_RST   = 3'h0;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// control bits as held in hardware
	typedef struct packed {
		logic       run;
		logic       single;
		logic       timeout;
		logic [1:0] presc_sel;
		logic       cap_mask;
		logic       to_mask;
		logic       route;
	} tcc_ctrl_s;

	// capture strobes from the narrow counter engine
	typedef struct packed {
		logic [7:0] count;
		logic       cap_high;
		logic       cap_low;
	} tcc_narrow_s;

	// whole state of the block
	typedef struct packed {
		tcc_ctrl_s   ctrl;
		logic        demod;
		logic [7:0]  reload_hi;
		logic [7:0]  reload_lo;
		logic [15:0] cap16;
		logic [7:0]  cap8_hi;
		logic [7:0]  cap8_lo;
		logic [15:0] count;
		logic [2:0]  presc;
		logic [2:0]  sync;
		logic        level;
		logic        armed;
		logic        wide_out;
		logic        pin;
		logic        cap_irq;
		logic        to_irq;
		logic        aw_got;
		logic        w_got;
		logic [7:0]  waddr;
		logic [7:0]  wdata;
		logic        wstrb0;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [7:0]  rdata;
	} tcc_state_s;
endpackage : tcc_pkg

// [tb/testbench.sv]
// self-checking bench for the wide timer control and capture block
`timescale 1ns/1ns
module testbench;
	logic                 aclk;           // system clock
	logic                 aresetn;        // sync reset, active low
	logic [7:0]           s_axi_awaddr;   // write address
	logic                 s_axi_awvalid;  // write address valid
	logic                 s_axi_awready;  // write address ready
	logic [31:0]          s_axi_wdata;    // write data
	logic [3:0]           s_axi_wstrb;    // byte strobes
	logic                 s_axi_wvalid;   // write data valid
	logic                 s_axi_wready;   // write data ready
	logic [1:0]           s_axi_bresp;    // write response
	logic                 s_axi_bvalid;   // write response valid
	logic                 s_axi_bready;   // held high: responses taken at once
	logic [7:0]           s_axi_araddr;   // read address
	logic                 s_axi_arvalid;  // read address valid
	logic                 s_axi_arready;  // read address ready
	logic [31:0]          s_axi_rdata;    // read data
	logic [1:0]           s_axi_rresp;    // read response
	logic                 s_axi_rvalid;   // read data valid
	logic                 s_axi_rready;   // held high: read data taken at once
	tcc_pkg::tcc_narrow_s narrow_in;      // narrow counter capture strobes
	logic                 demod_in;       // measured input, unused in transmit mode
	logic                 stop_recover;   // stop-mode recovery pulse
	logic                 port_out_data;  // ordinary port data
	logic                 timer_output_pin;
	logic                 wide_out;
	logic                 capture_irq_req;
	logic                 timeout_irq_req;
	logic [33:0]          rq[$];          // expected {rresp, rdata} in issue order
	logic [1:0]           wq[$];          // expected bresp in issue order
	int                   failures;       // mismatches seen
	int                   tests_run;      // comparisons made
	int                   to_pulses;      // timeout requests seen
	int                   cap_pulses;     // capture requests seen
	logic [7:0]           x;
	logic [7:0]           y;
	int                   m;              // demodulation gap in prescaler ticks
	logic [7:0]           map[8] = '{tcc_pkg::ADDR_CONTROL, tcc_pkg::ADDR_RELOAD_LO,
		tcc_pkg::ADDR_RELOAD_HI, tcc_pkg::ADDR_CAP16_LO, tcc_pkg::ADDR_CAP16_HI,
		tcc_pkg::ADDR_CAP8_LO, tcc_pkg::ADDR_CAP8_HI, tcc_pkg::ADDR_MODE};

	tcc_timer16 dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .narrow_in(narrow_in), .demod_in(demod_in),
		.stop_recover(stop_recover), .port_out_data(port_out_data),
		.timer_output_pin(timer_output_pin), .wide_out(wide_out),
		.capture_irq_req(capture_irq_req), .timeout_irq_req(timeout_irq_req));

	// 100 MHz clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// single comparison point; four-state equality so an unknown never matches a known value
	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// verdict and end of run
	task automatic stop_test;
		if (failures == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : stop_test

	// write one register; address and data released each on its own handshake
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		wq.push_back(er);
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (n == 64) failures++;
	endtask : wr

	// read one register; the expectation is queued before the request goes out
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
		int n;
		rq.push_back({er, 24'h0, e});
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (n == 64) failures++;
	endtask : rd

	// one-cycle capture strobe from the narrow counter
	task automatic pulse(input logic [7:0] c, input logic [1:0] k);
		@(posedge aclk);
		narrow_in <= {c, k};
		@(posedge aclk);
		narrow_in <= {c, 2'b00};
	endtask : pulse

	// output watcher: each response takes the oldest note; tags sit at the pushes
	always @(posedge aclk) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
		if (s_axi_bvalid === 1'b1 && s_axi_bready) chk({32'h0, s_axi_bresp}, {32'h0, wq.pop_front()});
		if (timeout_irq_req === 1'b1) to_pulses++;
		if (capture_irq_req === 1'b1) cap_pulses++;
	end

	// watchdog: the demodulation wrap alone needs some sixty-six thousand cycles
	initial begin
		repeat (80000) @(posedge aclk);
		failures++;
		stop_test();
	end

	// main sequence
	initial begin
		{failures, tests_run, to_pulses, cap_pulses} = '0;
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
		{s_axi_araddr, s_axi_arvalid, narrow_in, demod_in, stop_recover, port_out_data} = '0;
		s_axi_wstrb  = 4'hf;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		void'($urandom(32'hb58b98a0));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		// every mapped register starts cleared, a hole answers with an error
		foreach (map[i]) rd(map[i], 8'h00, 2'h0);
		rd(8'h04, 8'h00, 2'h2);
		wr(8'h04, 8'h55, 2'h2);
		// reload high byte holds what software writes; a masked strobe writes nothing
		x = 8'($urandom);
		wr(tcc_pkg::ADDR_RELOAD_HI, x, 2'h0);
		rd(tcc_pkg::ADDR_RELOAD_HI, x, 2'h0);
		s_axi_wstrb <= 4'he;
		wr(tcc_pkg::ADDR_RELOAD_HI, ~x, 2'h0);
		s_axi_wstrb <= 4'hf;
		rd(tcc_pkg::ADDR_RELOAD_HI, x, 2'h0);
		// narrow captures land in the register named by the strobe
		x = 8'($urandom);
		y = 8'($urandom);
		pulse(x, 2'b10);
		pulse(y, 2'b01);
		rd(tcc_pkg::ADDR_CAP8_HI, x, 2'h0);
		rd(tcc_pkg::ADDR_CAP8_LO, y, 2'h0);
		// software writes bounce off every capture register
		for (int i = 3; i < 7; i++) wr(map[i], 8'ha5, 2'h0);
		rd(tcc_pkg::ADDR_CAP16_LO, 8'h00, 2'h0);
		rd(tcc_pkg::ADDR_CAP16_HI, 8'h00, 2'h0);
		rd(tcc_pkg::ADDR_CAP8_LO, y, 2'h0);
		rd(tcc_pkg::ADDR_CAP8_HI, x, 2'h0);
		// pin follows port data, then the idle timer output once routed
		port_out_data <= 1'($urandom);
		repeat (3) @(posedge aclk);
		#1 chk({33'h0, timer_output_pin}, {33'h0, port_out_data});
		wr(tcc_pkg::ADDR_CONTROL, 8'h01, 2'h0);
		port_out_data <= 1'b1;
		repeat (3) @(posedge aclk);
		#1 chk({33'h0, timer_output_pin}, 34'h0);
		// single pass, divide by eight, reload 3: four ticks of eight cycles
		wr(tcc_pkg::ADDR_RELOAD_LO, 8'h03, 2'h0);
		wr(tcc_pkg::ADDR_RELOAD_HI, 8'h00, 2'h0);
		wr(tcc_pkg::ADDR_CONTROL, 8'hda, 2'h0);
		repeat (10) @(posedge aclk);
		rd(tcc_pkg::ADDR_CONTROL, 8'hda, 2'h0);
		repeat (60) @(posedge aclk);
		rd(tcc_pkg::ADDR_CONTROL, 8'h7a, 2'h0);
		chk({33'h0, wide_out}, 34'h1);
		chk(34'(to_pulses), 34'h1);
		chk(34'(cap_pulses), 34'h0);
		// writing zero to the flag keeps it; recovery keeps only some fields
		wr(tcc_pkg::ADDR_CONTROL, 8'h5f, 2'h0);
		rd(tcc_pkg::ADDR_CONTROL, 8'h7f, 2'h0);
		@(posedge aclk);
		stop_recover <= 1'b1;
		@(posedge aclk);
		stop_recover <= 1'b0;
		rd(tcc_pkg::ADDR_CONTROL, 8'h7c, 2'h0);
		wr(tcc_pkg::ADDR_CONTROL, 8'h20, 2'h0);
		rd(tcc_pkg::ADDR_CONTROL, 8'h00, 2'h0);
		// modulo-n at divide by four keeps running; stop first, then clear the flag
		wr(tcc_pkg::ADDR_CONTROL, 8'h90, 2'h0);
		repeat (30) @(posedge aclk);
		rd(tcc_pkg::ADDR_CONTROL, 8'hb0, 2'h0);
		wr(tcc_pkg::ADDR_CONTROL, 8'h00, 2'h0);
		wr(tcc_pkg::ADDR_CONTROL, 8'h20, 2'h0);
		rd(tcc_pkg::ADDR_CONTROL, 8'h00, 2'h0);
		chk(34'(to_pulses), 34'h1);
		// demodulation at divide by two: first edge arms, the next captures the
		// complement; an odd gap of 2m+1 cycles holds exactly m ticks
		m = 300 + int'($urandom % 400);
		wr(tcc_pkg::ADDR_MODE, 8'h01, 2'h0);
		rd(tcc_pkg::ADDR_MODE, 8'h01, 2'h0);
		wr(tcc_pkg::ADDR_CONTROL, 8'h8c, 2'h0);
		demod_in <= 1'b1;
		repeat (2 * m + 1) @(posedge aclk);
		demod_in <= 1'b0;
		repeat (8) @(posedge aclk);
		rd(tcc_pkg::ADDR_CAP16_LO, 8'(m), 2'h0);
		rd(tcc_pkg::ADDR_CAP16_HI, 8'(m >> 8), 2'h0);
		chk(34'(cap_pulses), 34'h1);
		// full speed until the counter runs through zero and wraps to full
		wr(tcc_pkg::ADDR_CONTROL, 8'h86, 2'h0);
		repeat (65600) @(posedge aclk);
		rd(tcc_pkg::ADDR_CONTROL, 8'ha6, 2'h0);
		chk(34'(to_pulses), 34'h2);
		repeat (3) @(posedge aclk);
		stop_test();
	end
endmodule : testbench
